//--- core/las_ack_setup.sv
// Acknowledge-cycle SDA setup timer used during remote accesses
`timescale 1ns/100ps
module las_ack_setup (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ack_start,
  input  wire logic [3:0] setup_field,
  output logic            setup_busy,
  output logic            setup_done
);

  typedef struct packed {
    las_pkg::las_ack_state_e            state;
    logic [las_pkg::LAS_SETUP_CNT_W-1:0] cnt;
    logic                               busy;
    logic                               done;
  } las_ack_s;

  las_ack_s st_reg;
  las_ack_s st_next;

  // Whole setup in cycles: nominal part plus field times the unit step
  function automatic logic [las_pkg::LAS_SETUP_CNT_W-1:0] setup_cycles(input logic [3:0] f);
    setup_cycles = las_pkg::LAS_SETUP_CNT_W'(las_pkg::LAS_SETUP_NOM_CYC)
                 + las_pkg::LAS_SETUP_CNT_W'(f)
                 * las_pkg::LAS_SETUP_CNT_W'(las_pkg::LAS_SETUP_UNIT_CYC);
  endfunction

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      las_pkg::LAS_ACK_IDLE: begin
        if (ack_start) begin
          st_next.cnt   = setup_cycles(setup_field) - las_pkg::LAS_SETUP_CNT_ONE; // R4 R5
          st_next.busy  = 1'b1;
          st_next.state = las_pkg::LAS_ACK_WAIT;
        end
      end
      las_pkg::LAS_ACK_WAIT: begin
        if (st_reg.cnt == las_pkg::LAS_SETUP_CNT_ZERO) begin
          st_next.busy  = 1'b0;
          st_next.done  = 1'b1;
          st_next.state = las_pkg::LAS_ACK_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - las_pkg::LAS_SETUP_CNT_ONE;
        end
      end
      default: begin
        st_next.state = las_pkg::LAS_ACK_IDLE;
        st_next.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '{state: las_pkg::LAS_ACK_IDLE, cnt: las_pkg::LAS_SETUP_CNT_ZERO,
                  busy: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign setup_busy = st_reg.busy;
  assign setup_done = st_reg.done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_setup_nominal;
    (ack_start && !st_reg.busy && setup_field == 4'h0) |=> setup_busy[*4] ##1 setup_done;
  endproperty
  a_setup_nominal: assert property (p_setup_nominal) // R5
    else $error("nominal ack setup is not four cycles");

  property p_setup_one_unit;
    (ack_start && !st_reg.busy && setup_field == 4'h1) |=> setup_busy ##36 setup_done;
  endproperty
  a_setup_one_unit: assert property (p_setup_one_unit) // R4
    else $error("ack setup with one unit is not 36 cycles");

  c_setup_done: cover property (setup_done);

endmodule // las_ack_setup

//--- core/las_regs.sv
// Remote alias decoder, ack setup control, back-channel CRC counter and general status
//
// Function
// (R1) Nonzero alias match forwards with target address
// (R2) Alias zero disables remote target decoding
// (R3) Port-select bit banks per-port registers
// (R4) Ack setup lengthened by field times 640ns
// (R5) Field zero gives nominal 80ns setup
// (R6) 16-bit CRC count, low then high
// (R7) Counter clears only by error-clear control
// (R8) Status bit 6 ORs video errors
// (R9) Status bit 5 ORs lane errors
// (R10) Link-lost sticky until error clear
// (R11) Self-test CRC flag cleared by restart/clear
// (R12) Bit 2 shows selected port pixel clock
// (R13) Remote CRC flag cleared by loss/clear
// (R14) Bit 0 shows selected port link
// (R15) Per-port 7-bit remote target address held
// (R16) Reserved bits read zero, writes ignored
`timescale 1ns/100ps
module las_regs (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        second_port_select,
  input  wire logic        error_clear,
  input  wire logic        i2c_addr_valid,
  input  wire logic [6:0]  i2c_addr,
  output logic             fwd_valid,
  output logic             fwd_port,
  output logic      [6:0]  fwd_target_addr,
  input  wire logic        remote_access,
  input  wire logic        ack_start,
  output logic             ack_setup_busy,
  output logic             ack_setup_done,
  input  wire logic [9:0]  video_err,
  input  wire logic [1:0]  lane_sync_err,
  input  wire logic [1:0]  lane_fault,
  input  wire logic [1:0]  link_detect,
  input  wire logic [1:0]  link_lost_evt,
  input  wire logic [1:0]  bc_crc_evt,
  input  wire logic [1:0]  selftest_restart,
  input  wire logic [1:0]  selftest_crc_evt,
  input  wire logic [1:0]  remote_crc_evt,
  input  wire logic [1:0]  pclk_valid
);

  localparam int NP = las_pkg::LAS_PORTS;

  typedef struct packed {
    logic [NP-1:0][6:0]  alias_id;
    logic [NP-1:0][6:0]  target_id;
    logic [3:0]          setup;
    logic [NP-1:0][15:0] crc_cnt;
    logic [NP-1:0]       link_lost;
    logic [NP-1:0]       st_crc;
    logic [NP-1:0]       rem_crc;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                fwd_valid;
    logic                fwd_port;
    logic [6:0]          fwd_addr;
  } las_state_s;

  las_state_s st_reg;
  las_state_s st_next;

  // Shared by the write path and the assertions
  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    hits = (a == ofs);
  endfunction

  function automatic logic [7:0] addr_byte(input logic [6:0] a);
    addr_byte = {a, 1'b0};
  endfunction

  // Both ports decode; port 0 wins if both aliases happen to match
  function automatic logic alias_match(input logic [6:0] al, input logic [6:0] a);
    alias_match = (al != las_pkg::LAS_ADDR_RST) && (al == a); // R1 R2
  endfunction

  logic       sel;
  logic [7:0] status_byte;
  logic [7:0] rd_mux;

  assign sel = second_port_select;

  always_comb begin
    status_byte = las_pkg::LAS_BYTE_ZERO; // R16
    status_byte[las_pkg::LAS_STS_VIDEO]  = |video_err; // R8
    status_byte[las_pkg::LAS_STS_LANE]   = |{lane_sync_err, lane_fault}; // R9
    status_byte[las_pkg::LAS_STS_LOST]   = st_reg.link_lost[sel]; // R10 R3
    status_byte[las_pkg::LAS_STS_STCRC]  = st_reg.st_crc[sel]; // R11
    status_byte[las_pkg::LAS_STS_PCLK]   = pclk_valid[sel]; // R12
    status_byte[las_pkg::LAS_STS_REMCRC] = st_reg.rem_crc[sel]; // R13
    status_byte[las_pkg::LAS_STS_LINK]   = link_detect[sel]; // R14
  end

  always_comb begin
    rd_mux = las_pkg::LAS_BYTE_ZERO;
    case (reg_addr)
      las_pkg::LAS_OFS_TARGET: rd_mux = addr_byte(st_reg.target_id[sel]); // R15 R3
      las_pkg::LAS_OFS_ALIAS:  rd_mux = addr_byte(st_reg.alias_id[sel]); // R3
      las_pkg::LAS_OFS_SETUP:  rd_mux = {4'h0, st_reg.setup}; // R16
      las_pkg::LAS_OFS_CNT_LO: rd_mux = st_reg.crc_cnt[sel][7:0]; // R6
      las_pkg::LAS_OFS_CNT_HI: rd_mux = st_reg.crc_cnt[sel][15:8]; // R6
      las_pkg::LAS_OFS_STATUS: rd_mux = status_byte;
      default:                 rd_mux = las_pkg::LAS_BYTE_ZERO;
    endcase
  end

  always_comb begin
    logic clr;
    clr = 1'b0;
    st_next           = st_reg;
    st_next.rvalid    = reg_rd_en;
    st_next.rdata     = reg_rd_en ? rd_mux : st_reg.rdata;
    st_next.fwd_valid = 1'b0;

    // Target and alias writes reach only the copy that the port select points at; setup has one copy
    if (reg_wr_en) begin
      if (hits(reg_addr, las_pkg::LAS_OFS_TARGET)) begin
        st_next.target_id[sel] = reg_wdata[las_pkg::LAS_ADDR_MSB:las_pkg::LAS_ADDR_LSB]; // R15 R3
      end
      if (hits(reg_addr, las_pkg::LAS_OFS_ALIAS)) begin
        st_next.alias_id[sel] = reg_wdata[las_pkg::LAS_ADDR_MSB:las_pkg::LAS_ADDR_LSB]; // R3
      end
      if (hits(reg_addr, las_pkg::LAS_OFS_SETUP)) begin
        st_next.setup = reg_wdata[las_pkg::LAS_SETUP_MSB:0]; // R16
      end
    end

    if (i2c_addr_valid) begin
      if (alias_match(st_reg.alias_id[0], i2c_addr)) begin
        st_next.fwd_valid = 1'b1; // R1
        st_next.fwd_port  = 1'b0;
        st_next.fwd_addr  = st_reg.target_id[0]; // R15
      end else if (alias_match(st_reg.alias_id[1], i2c_addr)) begin
        st_next.fwd_valid = 1'b1; // R1
        st_next.fwd_port  = 1'b1;
        st_next.fwd_addr  = st_reg.target_id[1]; // R15
      end
    end

    // An event with a clear in the same cycle sets the flag, and the counter restarts at one
    for (int p = 0; p < NP; p++) begin
      clr = error_clear && (sel == 1'(p));
      if (bc_crc_evt[p]) begin
        if (clr) begin
          st_next.crc_cnt[p] = las_pkg::LAS_CNT_ONE; // R7
        end else if (st_reg.crc_cnt[p] != las_pkg::LAS_CNT_MAX) begin
          st_next.crc_cnt[p] = st_reg.crc_cnt[p] + las_pkg::LAS_CNT_ONE; // R6
        end
      end else if (clr) begin
        st_next.crc_cnt[p] = las_pkg::LAS_CNT_RST; // R7
      end
      st_next.link_lost[p] = link_lost_evt[p] || (st_reg.link_lost[p] && !clr); // R10
      st_next.st_crc[p]    = selftest_crc_evt[p]
                          || (st_reg.st_crc[p] && !clr && !selftest_restart[p]); // R11
      st_next.rem_crc[p]   = remote_crc_evt[p]
                          || (st_reg.rem_crc[p] && !clr && !link_lost_evt[p]); // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '{alias_id:  {NP{las_pkg::LAS_ADDR_RST}},
                  target_id: {NP{las_pkg::LAS_ADDR_RST}},
                  setup:     las_pkg::LAS_SETUP_RST,
                  crc_cnt:   {NP{las_pkg::LAS_CNT_RST}},
                  link_lost: '0,
                  st_crc:    '0,
                  rem_crc:   '0,
                  rdata:     las_pkg::LAS_BYTE_ZERO,
                  rvalid:    1'b0,
                  fwd_valid: 1'b0,
                  fwd_port:  1'b0,
                  fwd_addr:  las_pkg::LAS_ADDR_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // Ack setup only matters while a remote access owns the bus
  las_ack_setup u_ack_setup (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .ack_start   (ack_start && remote_access), // R4
    .setup_field (st_reg.setup),
    .setup_busy  (ack_setup_busy),
    .setup_done  (ack_setup_done)
  );

  assign reg_rdata       = st_reg.rdata;
  assign reg_rvalid      = st_reg.rvalid;
  assign fwd_valid       = st_reg.fwd_valid;
  assign fwd_port        = st_reg.fwd_port;
  assign fwd_target_addr = st_reg.fwd_addr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_alias_fwd;
    (i2c_addr_valid && st_reg.alias_id[0] != 7'h00 && i2c_addr == st_reg.alias_id[0])
      |=> (fwd_valid && !fwd_port && fwd_target_addr == $past(st_reg.target_id[0]));
  endproperty
  a_alias_fwd: assert property (p_alias_fwd) // R1
    else $error("alias hit on port 0 not forwarded with its target address");

  property p_alias_zero;
    (i2c_addr_valid && st_reg.alias_id[0] == 7'h00 && st_reg.alias_id[1] == 7'h00)
      |=> !fwd_valid;
  endproperty
  a_alias_zero: assert property (p_alias_zero) // R2
    else $error("forward issued while both aliases are zero");

  property p_target_fwd;
    // The port index must be today's, the stored addresses those of the decode cycle
    fwd_valid |-> fwd_target_addr == (fwd_port ? $past(st_reg.target_id[1])
                                               : $past(st_reg.target_id[0]));
  endproperty
  a_target_fwd: assert property (p_target_fwd) // R15
    else $error("forwarded address differs from the stored target address");

  property p_bank_read;
    (reg_rd_en && hits(reg_addr, las_pkg::LAS_OFS_ALIAS))
      |=> (reg_rvalid && reg_rdata == {$past(st_reg.alias_id[sel]), 1'b0});
  endproperty
  a_bank_read: assert property (p_bank_read) // R3
    else $error("alias read does not return the selected port copy");

  property p_cnt_inc;
    (bc_crc_evt[0] && !(error_clear && !sel) && st_reg.crc_cnt[0] != 16'hFFFF)
      |=> st_reg.crc_cnt[0] == $past(st_reg.crc_cnt[0]) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) // R6
    else $error("back-channel CRC counter did not step by one");

  property p_cnt_no_read_clear;
    (reg_rd_en && !bc_crc_evt[0] && !(error_clear && !sel)) |=> $stable(st_reg.crc_cnt[0]);
  endproperty
  a_cnt_no_read_clear: assert property (p_cnt_no_read_clear) // R7
    else $error("CRC counter changed without an event or a clear");

  property p_video_or;
    (reg_rd_en && hits(reg_addr, las_pkg::LAS_OFS_STATUS))
      |=> (reg_rdata[6] == $past(|video_err)
           && reg_rdata[5] == $past(|{lane_sync_err, lane_fault}));
  endproperty
  a_video_or: assert property (p_video_or) // R8 R9
    else $error("status error summary bits do not match their sources");

  property p_lost_sticky;
    (st_reg.link_lost[0] && !(error_clear && !sel)) |=> st_reg.link_lost[0];
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) // R10
    else $error("link-lost flag dropped without error clear");

  property p_st_restart;
    (selftest_restart[0] && !selftest_crc_evt[0]) |=> !st_reg.st_crc[0];
  endproperty
  a_st_restart: assert property (p_st_restart) // R11
    else $error("self-test CRC flag survived a restart");

  property p_rem_lost;
    (link_lost_evt[0] && !remote_crc_evt[0]) |=> !st_reg.rem_crc[0];
  endproperty
  a_rem_lost: assert property (p_rem_lost) // R13
    else $error("remote CRC flag survived loss of link");

  property p_live_bits;
    (reg_rd_en && hits(reg_addr, las_pkg::LAS_OFS_STATUS))
      |=> (reg_rdata[2] == $past(pclk_valid[sel]) && reg_rdata[0] == $past(link_detect[sel])
           && reg_rdata[7] == 1'b0);
  endproperty
  a_live_bits: assert property (p_live_bits) // R12 R14 R16
    else $error("pixel clock or link detect bit wrong for selected port");

  property p_setup_rsvd;
    (reg_rd_en && hits(reg_addr, las_pkg::LAS_OFS_SETUP)) |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_setup_rsvd: assert property (p_setup_rsvd) // R16
    else $error("reserved setup bits read nonzero");

  c_alias_hit:  cover property (fwd_valid && fwd_port);
  c_cnt_hi:     cover property (reg_rd_en && hits(reg_addr, las_pkg::LAS_OFS_CNT_HI)
                                && st_reg.crc_cnt[sel][15:8] != 8'h00);
  c_lost_clear: cover property (st_reg.link_lost[0] ##1 !st_reg.link_lost[0]);
  c_ack_done:   cover property (ack_setup_done);

endmodule // las_regs

//--- shared/las_pkg.sv
// Constants and types shared by the link alias and status register slice
package las_pkg;

  // Register offsets
  localparam logic [7:0] LAS_OFS_TARGET   = 8'h07;
  localparam logic [7:0] LAS_OFS_ALIAS    = 8'h08;
  localparam logic [7:0] LAS_OFS_SETUP    = 8'h09;
  localparam logic [7:0] LAS_OFS_CNT_LO   = 8'h0A;
  localparam logic [7:0] LAS_OFS_CNT_HI   = 8'h0B;
  localparam logic [7:0] LAS_OFS_STATUS   = 8'h0C;

  // Reset values, counter step and counter limit
  localparam logic [6:0]  LAS_ADDR_RST    = 7'h00;
  localparam logic [3:0]  LAS_SETUP_RST   = 4'h1;
  localparam logic [15:0] LAS_CNT_RST     = 16'h0000;
  localparam logic [15:0] LAS_CNT_ONE     = 16'h0001;
  localparam logic [15:0] LAS_CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  LAS_BYTE_ZERO   = 8'h00;

  // Sizes and field positions
  localparam int LAS_PORTS      = 2;
  localparam int LAS_VID_SRC    = 5;
  localparam int LAS_ADDR_LSB   = 1;
  localparam int LAS_ADDR_MSB   = 7;
  localparam int LAS_SETUP_MSB  = 3;
  localparam int LAS_STS_VIDEO  = 6;
  localparam int LAS_STS_LANE   = 5;
  localparam int LAS_STS_LOST   = 4;
  localparam int LAS_STS_STCRC  = 3;
  localparam int LAS_STS_PCLK   = 2;
  localparam int LAS_STS_REMCRC = 1;
  localparam int LAS_STS_LINK   = 0;

  // Acknowledge setup timing at 50 MHz; least times round up
  localparam int LAS_CLK_PERIOD_NS  = 20;
  localparam int LAS_SETUP_NOM_NS   = 80;
  localparam int LAS_SETUP_UNIT_NS  = 640;
  localparam int LAS_SETUP_NOM_CYC  =
    (LAS_SETUP_NOM_NS + LAS_CLK_PERIOD_NS - 1) / LAS_CLK_PERIOD_NS;
  localparam int LAS_SETUP_UNIT_CYC =
    (LAS_SETUP_UNIT_NS + LAS_CLK_PERIOD_NS - 1) / LAS_CLK_PERIOD_NS;
  localparam int LAS_SETUP_CNT_W    = 10;
  localparam logic [9:0] LAS_SETUP_CNT_ZERO = 10'h000;
  localparam logic [9:0] LAS_SETUP_CNT_ONE  = 10'h001;

  typedef enum logic [1:0] {
    LAS_ACK_IDLE = 2'b00,
    LAS_ACK_WAIT = 2'b01
  } las_ack_state_e;

endpackage

//--- testbench/las_partner.sv
// Remote side model: per-port link presence and one-cycle event pulses
`timescale 1ns/100ps
module las_partner (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ev_go,
  input  wire logic [2:0] ev_kind,
  input  wire logic [1:0] ev_ports,
  input  wire logic [1:0] up_req,
  output logic      [1:0] link_detect,
  output logic      [1:0] link_lost_evt,
  output logic      [1:0] bc_crc_evt,
  output logic      [1:0] selftest_restart,
  output logic      [1:0] selftest_crc_evt,
  output logic      [1:0] remote_crc_evt
);
  logic [4:0][1:0] ev_reg;

  always_ff @(posedge core_clk) begin
    ev_reg <= '0;
    if (!rst_b) begin
      link_detect <= 2'h0;
    end else begin
      // A lost link drops detect too, as a real cable fault would
      link_detect <= up_req & ~((ev_go && ev_kind == 3'h0) ? ev_ports : 2'h0);
      // A held request repeats the event every cycle
      if (ev_go) begin
        ev_reg[ev_kind] <= ev_ports;
      end
    end
  end

  assign link_lost_evt    = ev_reg[0];
  assign bc_crc_evt       = ev_reg[1];
  assign selftest_restart = ev_reg[2];
  assign selftest_crc_evt = ev_reg[3];
  assign remote_crc_evt   = ev_reg[4];
endmodule // las_partner

//--- testbench/tb.sv
// Self-checking bench for the alias, ack setup, error counter and status registers
`timescale 1ns/100ps
module tb;
  logic        core_clk, rst_b, reg_wr_en, reg_rd_en, reg_rvalid, second_port_select;
  logic        error_clear, i2c_addr_valid, fwd_valid, fwd_port, remote_access, ack_start;
  logic        ack_setup_busy, ack_setup_done, ev_go;
  logic [1:0]  lane_sync_err, lane_fault, link_detect, link_lost_evt, bc_crc_evt, pclk_valid;
  logic [1:0]  selftest_restart, selftest_crc_evt, remote_crc_evt, ev_ports, up_req;
  logic [2:0]  ev_kind;
  logic [6:0]  i2c_addr, fwd_target_addr;
  logic [6:0]  al [2];
  logic [6:0]  tg [2];
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  rd_q [$];
  logic [7:0]  fwd_q [$];
  logic [9:0]  video_err;
  logic [15:0] n, k;
  logic [31:0] seed, r;
  int          n_mismatch, n_compared, i;

  las_regs u_dut (.core_clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .second_port_select, .error_clear, .i2c_addr_valid, .i2c_addr,
    .fwd_valid, .fwd_port, .fwd_target_addr, .remote_access, .ack_start, .ack_setup_busy,
    .ack_setup_done, .video_err, .lane_sync_err, .lane_fault, .link_detect, .link_lost_evt,
    .bc_crc_evt, .selftest_restart, .selftest_crc_evt, .remote_crc_evt, .pclk_valid);
  las_partner u_far (.core_clk, .rst_b, .ev_go, .ev_kind, .ev_ports, .up_req, .link_detect,
    .link_lost_evt, .bc_crc_evt, .selftest_restart, .selftest_crc_evt, .remote_crc_evt);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    chk(16'(rd_q.size() + fwd_q.size()), 16'h0000);
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  // Expected data is queued here and checked when the answer appears
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
  endtask

  task automatic snd(input logic [6:0] a, input logic hit, input logic [7:0] exp);
    if (hit) begin
      fwd_q.push_back(exp);
    end
    @(posedge core_clk);
    i2c_addr_valid <= 1'b1;
    i2c_addr <= a;
    @(posedge core_clk);
    i2c_addr_valid <= 1'b0;
  endtask

  task automatic ev(input logic [2:0] kind, input logic [1:0] ports);
    @(posedge core_clk);
    ev_go <= 1'b1;
    ev_kind <= kind;
    ev_ports <= ports;
    @(posedge core_clk);
    ev_go <= 1'b0;
  endtask

  task automatic clr();
    @(posedge core_clk);
    error_clear <= 1'b1;
    @(posedge core_clk);
    error_clear <= 1'b0;
  endtask

  task automatic ack_run(output logic [15:0] cnt);
    int j;
    cnt = 16'h0000;
    @(posedge core_clk);
    ack_start <= 1'b1;
    @(posedge core_clk);
    ack_start <= 1'b0;
    for (j = 0; j < 1000; j++) begin
      @(posedge core_clk);
      if (ack_setup_done === 1'b1) break;
      if (ack_setup_busy === 1'b1) cnt++;
    end
    if (j == 1000) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  always @(posedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) chk(16'h0001, 16'h0000);
      else chk({8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
    end
    if (fwd_valid === 1'b1) begin
      if (fwd_q.size() == 0) chk(16'h0002, 16'h0000);
      else chk({8'h00, fwd_port, fwd_target_addr}, {8'h00, fwd_q.pop_front()});
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, second_port_select, error_clear} = '0;
    {i2c_addr_valid, i2c_addr, remote_access, ack_start, video_err, lane_sync_err} = '0;
    {lane_fault, pclk_valid, ev_go, ev_kind, ev_ports, up_req, rst_b, n_mismatch} = '0;
    n_compared = 0;
    seed = 32'h8BD0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (i = 7; i < 13; i++) rd(8'(i), (i == 9) ? 8'h01 : 8'h00);
    rd(8'h3F, 8'h00);
    r = rnd();
    al[0] = r[6:0] | 7'h01;
    al[1] = al[0] ^ 7'h40;
    tg[0] = r[14:8];
    tg[1] = r[22:16];
    for (i = 0; i < 2; i++) begin
      second_port_select <= i[0];
      wr(las_pkg::LAS_OFS_ALIAS, {al[i], 1'b1});
      wr(las_pkg::LAS_OFS_TARGET, {tg[i], 1'b1});
      wr(las_pkg::LAS_OFS_STATUS, 8'hFF);
      wr(las_pkg::LAS_OFS_CNT_LO, 8'hFF);
    end
    for (i = 0; i < 2; i++) begin
      second_port_select <= i[0];
      rd(las_pkg::LAS_OFS_ALIAS, {al[i], 1'b0});
      rd(las_pkg::LAS_OFS_TARGET, {tg[i], 1'b0});
      rd(las_pkg::LAS_OFS_STATUS, 8'h00);
      rd(las_pkg::LAS_OFS_CNT_LO, 8'h00);
    end
    snd(al[0], 1'b1, {1'b0, tg[0]});
    snd(al[1], 1'b1, {1'b1, tg[1]});
    snd(al[0] ^ 7'h01, 1'b0, 8'h00);
    wr(las_pkg::LAS_OFS_ALIAS, 8'h00);
    snd(al[1], 1'b0, 8'h00);
    snd(7'h00, 1'b0, 8'h00);
    // A start outside a remote access must not run the timer
    @(posedge core_clk);
    ack_start <= 1'b1;
    @(posedge core_clk);
    ack_start <= 1'b0;
    @(posedge core_clk);
    chk({15'h0000, ack_setup_busy}, 16'h0000);
    remote_access <= 1'b1;
    for (i = 0; i < 3; i++) begin
      k = (i == 2) ? 16'h000F : 16'(i);
      wr(las_pkg::LAS_OFS_SETUP, {4'hF, k[3:0]});
      rd(las_pkg::LAS_OFS_SETUP, {4'h0, k[3:0]});
      ack_run(n);
      chk(n, 16'(las_pkg::LAS_SETUP_NOM_CYC + las_pkg::LAS_SETUP_UNIT_CYC * k));
    end
    // Held error level counts once per cycle, enough to reach the high byte
    second_port_select <= 1'b0;
    k = 16'h0100 + 16'(rnd() & 32'h3F);
    @(posedge core_clk);
    ev_go <= 1'b1;
    ev_kind <= 3'h1;
    ev_ports <= 2'b01;
    repeat (k) @(posedge core_clk);
    ev_go <= 1'b0;
    rd(las_pkg::LAS_OFS_CNT_LO, k[7:0]);
    rd(las_pkg::LAS_OFS_CNT_HI, k[15:8]);
    rd(las_pkg::LAS_OFS_CNT_LO, k[7:0]);
    second_port_select <= 1'b1;
    rd(las_pkg::LAS_OFS_CNT_LO, 8'h00);
    clr();
    second_port_select <= 1'b0;
    rd(las_pkg::LAS_OFS_CNT_HI, k[15:8]);
    clr();
    rd(las_pkg::LAS_OFS_CNT_LO, 8'h00);
    up_req <= 2'b11;
    pclk_valid <= 2'b10;
    rd(las_pkg::LAS_OFS_STATUS, 8'h01);
    second_port_select <= 1'b1;
    rd(las_pkg::LAS_OFS_STATUS, 8'h05);
    second_port_select <= 1'b0;
    for (i = 0; i < 10; i++) begin
      video_err <= 10'h001 << i;
      rd(las_pkg::LAS_OFS_STATUS, 8'h41);
    end
    video_err <= 10'h000;
    lane_fault <= 2'b10;
    rd(las_pkg::LAS_OFS_STATUS, 8'h21);
    lane_fault <= 2'b00;
    lane_sync_err <= 2'b01;
    rd(las_pkg::LAS_OFS_STATUS, 8'h21);
    lane_sync_err <= 2'b00;
    ev(3'h4, 2'b01);
    rd(las_pkg::LAS_OFS_STATUS, 8'h03);
    rd(las_pkg::LAS_OFS_STATUS, 8'h03);
    ev(3'h0, 2'b01);
    rd(las_pkg::LAS_OFS_STATUS, 8'h11);
    clr();
    rd(las_pkg::LAS_OFS_STATUS, 8'h01);
    second_port_select <= 1'b1;
    ev(3'h3, 2'b10);
    rd(las_pkg::LAS_OFS_STATUS, 8'h0D);
    ev(3'h2, 2'b10);
    rd(las_pkg::LAS_OFS_STATUS, 8'h05);
    ev(3'h3, 2'b10);
    clr();
    rd(las_pkg::LAS_OFS_STATUS, 8'h05);
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule // tb
